/* File: hw/vpd_page_responder.sv */
`timescale 1ns/100ps

// Summary of operation
// - decode page code into page kinds
// - four byte header, length is total minus four
// - page length ignores allocation truncation
// - description length at byte four, text follows
// - description length ignores allocation truncation
// - zero description length means no text
// - text lines printable, each nul terminated
// - info page echoes requested page code
// - unit codes above 127 get no page
// - info length at byte four, text follows
// - info length full; zero means no text
// - info lines printable, each nul terminated
// - pages sent only for vpd inquiry requests
// - supported list ascending from code zero
// - missing serial number reads as spaces

module vpd_page_responder
    import vpd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // inquiry request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_evpd,
    input wire logic [7:0] req_page_code,
    input wire logic [7:0] req_alloc_len,
    // request outcome
    output logic resp_done,
    output logic resp_reject,
    output logic busy,
    // byte stream toward the initiator
    output logic data_valid,
    input wire logic data_ready,
    output logic [7:0] data_byte,
    output logic data_last,
    // device identity and state
    input wire logic [2:0] periph_qual,
    input wire logic [4:0] periph_type,
    input wire logic [7:0] fru_code,
    input wire logic serial_valid,
    input wire logic [SERIAL_LEN*8-1:0] serial_num,
    input wire logic [6:0] opdef_current,
    input wire logic [6:0] opdef_default,
    input wire logic opdef_savimp,
    // text loading
    input wire logic load_clear,
    input wire logic load_valid,
    input wire logic load_sel,
    input wire logic [7:0] load_byte,
    output logic load_full
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        resp_state_t st;
        page_kind_t kind;
        logic [7:0] code;
        logic [7:0] text_len;
        logic [7:0] limit;
        logic [7:0] idx;
        logic [7:0] dbyte;
        logic dvalid;
        logic dlast;
        logic done;
        logic reject;
    } resp_t;

    resp_t s_reg;
    resp_t s_next;
    logic [TEXT_LW-1:0] desc_len;
    logic [TEXT_LW-1:0] info_len;
    logic [7:0] text_byte;
    logic [7:0] rd_off;
    logic has_info;
    logic [7:0] list_cnt;
    logic [7:0] total;
    logic [7:0] acc_text_len;
    page_kind_t acc_kind;
    logic acc_ok;
    logic [7:0] cur_byte;

    // ------------------------------------------------------------
    // text storage
    // ------------------------------------------------------------
    assign rd_off = s_reg.idx - TEXT_START;

    vpd_text_store u_text (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load_clear(load_clear),
        .load_valid(load_valid),
        .load_sel(load_sel),
        .load_byte(load_byte),
        .load_full(load_full),
        .rd_sel(s_reg.kind == KIND_INFO ? SEL_INFO : SEL_DESC),
        .rd_idx(rd_off[TEXT_AW-1:0]),
        .rd_byte(text_byte),
        .desc_len(desc_len),
        .info_len(info_len)
    );

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // only the configured unit code owns text; codes above 7fh never do
    assign has_info = fru_code >= PAGE_INFO_MIN && fru_code <= PAGE_INFO_MAX;
    assign list_cnt = LIST_BASE_CNT + {7'b0, has_info};

    // classify the page; reserved and vendor codes are refused
    always_comb
    begin
        acc_ok = req_evpd;
        acc_text_len = 8'h00;
        acc_kind = KIND_LIST;
        if (req_page_code == PAGE_LIST)
        begin
            acc_kind = KIND_LIST;
        end
        else if (req_page_code <= PAGE_INFO_MAX)
        begin
            acc_kind = KIND_INFO;
            if (req_page_code == fru_code)
                acc_text_len = {2'b0, info_len};
        end
        else if (req_page_code == PAGE_SERIAL)
        begin
            acc_kind = KIND_SERIAL;
        end
        else if (req_page_code == PAGE_OPDEF)
        begin
            acc_kind = KIND_OPDEF;
        end
        else if (req_page_code == PAGE_ASCII_OPDEF)
        begin
            acc_kind = KIND_AOPDEF;
            acc_text_len = {2'b0, desc_len};
        end
        else
        begin
            acc_ok = 1'b0;
        end
    end

    // full page size in bytes, header included
    always_comb
    begin
        case (acc_kind)
            KIND_LIST: total = HDR_LEN + list_cnt;
            KIND_SERIAL: total = SERIAL_TOTAL;
            KIND_OPDEF: total = OPDEF_TOTAL;
            default: total = TEXT_START + acc_text_len;
        endcase
    end

    // ------------------------------------------------------------
    // page byte generator
    // ------------------------------------------------------------
    // byte at the current index, built from live device state
    always_comb
    begin
        logic [7:0] p;
        logic [7:0] q;
        p = s_reg.idx - HDR_LEN;
        q = 8'h00;
        cur_byte = 8'h00;
        if (s_reg.idx == IDX_QUAL)
        begin
            cur_byte = {periph_qual, periph_type};
        end
        else if (s_reg.idx == IDX_CODE)
        begin
            cur_byte = s_reg.code;
        end
        else if (s_reg.idx == IDX_RSVD)
        begin
            cur_byte = 8'h00;
        end
        else if (s_reg.idx == IDX_PLEN)
        begin
            // length counts the whole page, never the truncated transfer
            case (s_reg.kind)
                KIND_LIST: cur_byte = list_cnt;
                KIND_SERIAL: cur_byte = SERIAL_TOTAL - HDR_LEN;
                KIND_OPDEF: cur_byte = OPDEF_TOTAL - HDR_LEN;
                default: cur_byte = s_reg.text_len + 8'h01;
            endcase
        end
        else
        begin
            case (s_reg.kind)
                KIND_LIST:
                begin
                    // without an info page the list skips slot one
                    if (has_info || p == 8'h00)
                        q = p;
                    else
                        q = p + 8'h01;
                    case (q)
                        8'h00: cur_byte = PAGE_LIST;
                        8'h01: cur_byte = fru_code;
                        8'h02: cur_byte = PAGE_SERIAL;
                        8'h03: cur_byte = PAGE_OPDEF;
                        default: cur_byte = PAGE_ASCII_OPDEF;
                    endcase
                end
                KIND_SERIAL:
                begin
                    // first character first, so the last sent is the lsb one
                    if (serial_valid)
                        cur_byte = serial_num[(SERIAL_LEN - 1 - p[2:0]) * 8 +: 8];
                    else
                        cur_byte = CHAR_SPACE;
                end
                KIND_OPDEF:
                begin
                    case (p)
                        8'h00: cur_byte = {1'b0, opdef_current};
                        8'h01: cur_byte = {opdef_savimp, opdef_default};
                        default: cur_byte = {opdef_savimp, opdef_current};
                    endcase
                end
                default:
                begin
                    if (p == 8'h00)
                        cur_byte = s_reg.text_len;
                    else
                        cur_byte = text_byte;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // one byte per accepted beat; the output register is refilled on hand-off
    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.reject = 1'b0;
        case (s_reg.st)
            ST_IDLE:
            begin
                if (req_valid && !acc_ok)
                begin
                    s_next.reject = 1'b1;
                end
                else if (req_valid)
                begin
                    s_next.kind = acc_kind;
                    s_next.code = req_page_code;
                    s_next.text_len = acc_text_len;
                    s_next.idx = 8'h00;
                    if (req_alloc_len < total)
                        s_next.limit = req_alloc_len;
                    else
                        s_next.limit = total;
                    if (req_alloc_len == 8'h00)
                        s_next.done = 1'b1;
                    else
                        s_next.st = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (!s_reg.dvalid || data_ready)
                begin
                    if (s_reg.idx < s_reg.limit)
                    begin
                        s_next.dbyte = cur_byte;
                        s_next.dvalid = 1'b1;
                        s_next.dlast = s_reg.idx == s_reg.limit - 8'h01;
                        s_next.idx = s_reg.idx + 8'h01;
                    end
                    else
                    begin
                        s_next.dvalid = 1'b0;
                        s_next.dlast = 1'b0;
                        s_next.done = 1'b1;
                        s_next.st = ST_IDLE;
                    end
                end
            end
            default:
            begin
                s_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_reg <= '0;
        else if (ce)
            s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign req_ready = s_reg.st == ST_IDLE;
    assign busy = s_reg.st == ST_SEND;
    assign resp_done = s_reg.done;
    assign resp_reject = s_reg.reject;
    assign data_valid = s_reg.dvalid;
    assign data_byte = s_reg.dbyte;
    assign data_last = s_reg.dlast;

endmodule : vpd_page_responder

/* File: include/vpd_pkg.sv */
package vpd_pkg;

    // ------------------------------------------------------------
    // page codes
    // ------------------------------------------------------------
    localparam logic [7:0] PAGE_LIST = 8'h00;
    localparam logic [7:0] PAGE_INFO_MIN = 8'h01;
    localparam logic [7:0] PAGE_INFO_MAX = 8'h7f;
    localparam logic [7:0] PAGE_SERIAL = 8'h80;
    localparam logic [7:0] PAGE_OPDEF = 8'h81;
    localparam logic [7:0] PAGE_ASCII_OPDEF = 8'h82;
    localparam logic [7:0] PAGE_RSVD_MIN = 8'h83;
    localparam logic [7:0] PAGE_VENDOR_MIN = 8'hc0;

    // ------------------------------------------------------------
    // page layout
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_QUAL = 8'h00;
    localparam logic [7:0] IDX_CODE = 8'h01;
    localparam logic [7:0] IDX_RSVD = 8'h02;
    localparam logic [7:0] IDX_PLEN = 8'h03;
    localparam logic [7:0] HDR_LEN = 8'h04;
    localparam logic [7:0] TEXT_START = 8'h05;
    localparam logic [7:0] OPDEF_TOTAL = 8'h07;
    localparam logic [7:0] LIST_BASE_CNT = 8'h04;
    localparam int SERIAL_LEN = 8;
    localparam logic [7:0] SERIAL_TOTAL = 8'h0c;

    // ------------------------------------------------------------
    // text store
    // ------------------------------------------------------------
    localparam int TEXT_DEPTH = 31;
    localparam int TEXT_AW = 5;
    localparam int TEXT_LW = 6;
    localparam logic [7:0] CHAR_NUL = 8'h00;
    localparam logic [7:0] CHAR_SPACE = 8'h20;
    localparam logic [7:0] CHAR_TILDE = 8'h7e;
    localparam logic SEL_DESC = 1'b0;
    localparam logic SEL_INFO = 1'b1;

    // ------------------------------------------------------------
    // states and page kinds
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } resp_state_t;

    typedef enum logic [2:0] {
        KIND_LIST = 3'b000,
        KIND_INFO = 3'b001,
        KIND_SERIAL = 3'b010,
        KIND_OPDEF = 3'b011,
        KIND_AOPDEF = 3'b100
    } page_kind_t;

endpackage : vpd_pkg

/* File: hw/vpd_text_store.sv */
`timescale 1ns/100ps

module vpd_text_store
    import vpd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // loading side
    input wire logic load_clear,
    input wire logic load_valid,
    input wire logic load_sel,
    input wire logic [7:0] load_byte,
    output logic load_full,
    // reading side
    input wire logic rd_sel,
    input wire logic [TEXT_AW-1:0] rd_idx,
    output logic [7:0] rd_byte,
    output logic [TEXT_LW-1:0] desc_len,
    output logic [TEXT_LW-1:0] info_len
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0][TEXT_DEPTH-1:0][7:0] mem;
        logic [1:0][TEXT_AW-1:0] cnt;
    } text_t;

    text_t s_reg;
    text_t s_next;
    logic [7:0] clean_byte;
    logic [1:0] open_tail;

    // non-graphic bytes other than nul become spaces so every line stays printable
    always_comb
    begin
        if (load_byte == CHAR_NUL || (load_byte >= CHAR_SPACE && load_byte <= CHAR_TILDE))
            clean_byte = load_byte;
        else
            clean_byte = CHAR_SPACE;
    end

    // append writes; a full buffer drops further bytes
    always_comb
    begin
        s_next = s_reg;
        if (load_clear)
        begin
            s_next.cnt = '0;
        end
        else if (load_valid && s_reg.cnt[load_sel] != TEXT_AW'(TEXT_DEPTH))
        begin
            s_next.mem[load_sel][s_reg.cnt[load_sel]] = clean_byte;
            s_next.cnt[load_sel] = s_reg.cnt[load_sel] + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_reg <= '0;
        else if (ce)
            s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    // an unterminated last line gets a virtual nul, so lengths include it
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_tail
            assign open_tail[g] = (s_reg.cnt[g] != '0) &&
                (s_reg.mem[g][s_reg.cnt[g] - 1'b1] != CHAR_NUL);
        end
    endgenerate

    assign desc_len = {1'b0, s_reg.cnt[SEL_DESC]} + {5'b0, open_tail[SEL_DESC]};
    assign info_len = {1'b0, s_reg.cnt[SEL_INFO]} + {5'b0, open_tail[SEL_INFO]};
    assign load_full = s_reg.cnt[load_sel] == TEXT_AW'(TEXT_DEPTH);

    always_comb
    begin
        if (rd_idx < s_reg.cnt[rd_sel])
            rd_byte = s_reg.mem[rd_sel][rd_idx];
        else
            rd_byte = CHAR_NUL;
    end

endmodule : vpd_text_store

/* File: dv/vpd_page_responder_monitor.sv */
`timescale 1ns/100ps

module vpd_resp_checker
    import vpd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // request side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_evpd,
    input wire logic [7:0] req_page_code,
    input wire logic [7:0] req_alloc_len,
    input wire logic resp_done,
    input wire logic resp_reject,
    input wire logic busy,
    // byte stream
    input wire logic data_valid,
    input wire logic data_ready,
    input wire logic [7:0] data_byte,
    input wire logic data_last,
    input wire logic [2:0] periph_qual,
    input wire logic [4:0] periph_type
);
    // ----
    // bytes sent and the request behind them
    // ----
    logic [7:0] cnt_reg;
    logic [7:0] code_reg;
    logic [7:0] alloc_reg;
    logic took;

    assign took = ce && req_valid && req_ready;

    // counter restarts at each taken request
    always_ff @(posedge clk)
    begin
        if (rst || took)
            cnt_reg <= 8'h00;
        else if (ce && data_valid && data_ready)
            cnt_reg <= cnt_reg + 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (took)
        begin
            code_reg <= req_page_code;
            alloc_reg <= req_alloc_len;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_take_ok;
        took && req_evpd && req_page_code < PAGE_RSVD_MIN;
    endsequence
    sequence s_stream;
        busy && !req_ready ##1 data_valid;
    endsequence

    a_bad_refused: assert property (took && (!req_evpd || req_page_code >= PAGE_RSVD_MIN)
        |=> resp_reject && !busy && !data_valid) else $error("refusal missing");
    a_zero_alloc: assert property (s_take_ok ##0 req_alloc_len == 8'h00
        |=> resp_done && !data_valid) else $error("zero allocation not closed");
    a_stream_start: assert property (s_take_ok ##0 req_alloc_len != 8'h00
        |=> s_stream) else $error("stream did not start");
    a_byte_hold: assert property (data_valid && !data_ready
        |=> data_valid && $stable(data_byte) && $stable(data_last)) else $error("byte not held");
    a_alloc_bound: assert property (data_valid |-> cnt_reg < alloc_reg)
        else $error("sent past allocation");
    a_last_alloc: assert property (data_valid && cnt_reg == alloc_reg - 8'h01
        |-> data_last) else $error("last flag missing");
    a_last_done: assert property (data_valid && data_ready && data_last
        |=> resp_done && !data_valid ##1 !resp_done) else $error("done pulse wrong");
    a_hdr_qual: assert property (data_valid && cnt_reg == 8'h00
        |-> data_byte == {periph_qual, periph_type}) else $error("byte zero wrong");
    a_code_echo: assert property (data_valid && cnt_reg == 8'h01
        |-> data_byte == code_reg) else $error("page code not echoed");
    a_hdr_rsvd: assert property (data_valid && cnt_reg == 8'h02
        |-> data_byte == 8'h00) else $error("reserved byte not zero");
    a_freeze_hold: assert property (!ce
        |=> $stable(data_valid) && $stable(data_byte) && $stable(busy))
        else $error("stream moved while frozen");
endmodule : vpd_resp_checker

bind vpd_page_responder vpd_resp_checker i_vpd_resp_checker (
    .clk, .rst, .ce, .req_valid, .req_ready, .req_evpd, .req_page_code, .req_alloc_len,
    .resp_done, .resp_reject, .busy, .data_valid, .data_ready, .data_byte, .data_last,
    .periph_qual, .periph_type
);

/* File: dv/vpd_initiator.sv */
`timescale 1ns/100ps

module vpd_initiator
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pacing: slow accepts one byte in four cycles
    input wire logic slow,
    // frozen edges take nothing, as the block holds its byte then
    input wire logic ce,
    // byte stream
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    output logic data_ready
);
    logic [7:0] rx_q[$];
    logic [1:0] tick = 2'h0;

    initial data_ready = 1'b0;

    // take bytes on the edge, move ready just after it
    always @(posedge clk)
    begin
        if (!rst && ce && data_valid && data_ready)
            rx_q.push_back(data_byte);
        tick = tick + 2'h1;
        #1 data_ready = !rst && (!slow || tick == 2'h0);
    end
endmodule : vpd_initiator

/* File: dv/tb_top.sv */
`timescale 1ns/100ps

module tb_top
    import vpd_pkg::*;
;
    // clock, reset and request
    logic clk = 0, rst = 1, ce = 1, slow = 0;
    logic req_valid = 0, req_evpd = 0;
    logic [7:0] req_page_code = 8'h00, req_alloc_len = 8'h00;
    logic req_ready, resp_done, resp_reject, busy;
    // stream
    logic data_valid, data_ready, data_last;
    logic [7:0] data_byte;
    // identity and text loading
    logic [2:0] periph_qual = 3'h2;
    logic [4:0] periph_type = 5'h0d;
    logic [7:0] fru_code = 8'h05, load_byte = 8'h00;
    logic serial_valid = 0, opdef_savimp = 1, load_clear = 0, load_valid = 0, load_sel = 0;
    logic [SERIAL_LEN*8-1:0] serial_num = "ABCDEFGH";
    logic [6:0] opdef_current = 7'h03, opdef_default = 7'h01;
    logic load_full;
    localparam logic [7:0] HB = {3'h2, 5'h0d};
    int fails = 0, check_count = 0, cycles = 0;

    always #20 clk = ~clk;

    vpd_page_responder i_vpd_page_responder (.*);
    vpd_initiator i_vpd_initiator (.clk, .rst, .slow, .ce, .data_valid, .data_byte, .data_ready);

    // ----
    // helpers
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // empty page means a refusal is expected
    task automatic run(input logic [7:0] code, input logic [7:0] alloc,
                       input logic [7:0] pg[$], input logic ev = 1'b1);
        int n;
        int k;
        n = (pg.size() < alloc) ? pg.size() : alloc;
        // let an edge pass so back-to-back requests never share a time step
        @(posedge clk);
        #1 i_vpd_initiator.rx_q.delete();
        req_evpd = ev;
        req_page_code = code;
        req_alloc_len = alloc;
        req_valid = 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        k = 0;
        while (resp_done !== 1'b1 && resp_reject !== 1'b1 && k < 400)
        begin
            @(posedge clk);
            #1 k++;
        end
        chk({resp_done, resp_reject}, (pg.size() == 0) ? 2'b01 : 2'b10);
        chk(i_vpd_initiator.rx_q.size(), n);
        for (k = 0; k < n && k < i_vpd_initiator.rx_q.size(); k++)
            chk(i_vpd_initiator.rx_q[k], pg[k]);
    endtask : run

    // holds valid high across the whole string, one byte per edge
    task automatic load(input logic sel, input logic [7:0] q[$]);
        load_sel = sel;
        foreach (q[i])
        begin
            load_byte = q[i];
            load_valid = 1'b1;
            @(posedge clk);
            #1;
        end
        load_valid = 1'b0;
    endtask : load

    task automatic clear();
        load_clear = 1'b1;
        @(posedge clk);
        #1 load_clear = 1'b0;
    endtask : clear

    // ----
    // scenarios
    // ----
    task automatic t_refuse();
        run(8'h00, 8'hff, '{}, 1'b0);
        run(8'h83, 8'hff, '{});
        run(8'hbf, 8'hff, '{});
        run(8'hc0, 8'hff, '{});
        run(8'hff, 8'hff, '{});
        run(8'h80, 8'h00, '{HB});
    endtask : t_refuse

    task automatic t_list();
        run(8'h00, 8'hff, '{HB, 8'h00, 8'h00, 8'h05, 8'h00, 8'h05, 8'h80, 8'h81, 8'h82});
        fru_code = 8'h90;
        run(8'h00, 8'hff, '{HB, 8'h00, 8'h00, 8'h04, 8'h00, 8'h80, 8'h81, 8'h82});
        fru_code = 8'h7f;
        run(8'h00, 8'h04, '{HB, 8'h00, 8'h00, 8'h05});
        fru_code = 8'h05;
    endtask : t_list

    task automatic t_serial();
        run(8'h80, 8'hff, '{HB, 8'h80, 8'h00, 8'h08, 8'h20, 8'h20, 8'h20, 8'h20,
            8'h20, 8'h20, 8'h20, 8'h20});
        serial_valid = 1'b1;
        run(8'h80, 8'h06, '{HB, 8'h80, 8'h00, 8'h08, 8'h41, 8'h42});
    endtask : t_serial

    task automatic t_opdef();
        run(8'h81, 8'h03, '{HB, 8'h81, 8'h00});
        run(8'h81, 8'hff, '{HB, 8'h81, 8'h00, 8'h03, 8'h03, 8'h81, 8'h83});
    endtask : t_opdef

    // slow acceptance stalls the stream between bytes
    task automatic t_text();
        logic [7:0] f[$];
        slow = 1'b1;
        clear();
        load(1'b0, '{8'h48, 8'h49, 8'h00, 8'h58, 8'h07});
        run(8'h82, 8'hff, '{HB, 8'h82, 8'h00, 8'h07, 8'h06, 8'h48, 8'h49, 8'h00,
            8'h58, 8'h20, 8'h00});
        run(8'h82, 8'h06, '{HB, 8'h82, 8'h00, 8'h07, 8'h06, 8'h48});
        load(1'b1, '{8'h4f, 8'h4b, 8'h00});
        run(8'h05, 8'hff, '{HB, 8'h05, 8'h00, 8'h04, 8'h03, 8'h4f, 8'h4b, 8'h00});
        run(8'h06, 8'hff, '{HB, 8'h06, 8'h00, 8'h01, 8'h00});
        clear();
        run(8'h82, 8'hff, '{HB, 8'h82, 8'h00, 8'h01, 8'h00});
        repeat (31) f.push_back(8'h41);
        load(1'b0, f);
        chk(load_full, 1'b1);
        slow = 1'b0;
    endtask : t_text

    // clock enable low mid-stream must hold the byte and lose nothing
    task automatic t_freeze();
        logic [7:0] pg[$];
        int k;
        pg = '{HB, 8'h81, 8'h00, 8'h03, 8'h03, 8'h81, 8'h83};
        @(posedge clk);
        #1 i_vpd_initiator.rx_q.delete();
        req_evpd = 1'b1;
        req_page_code = 8'h81;
        req_alloc_len = 8'hff;
        req_valid = 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1 ce = 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({busy, data_valid, data_byte}, {2'b11, 8'h81});
        ce = 1'b1;
        k = 0;
        while (resp_done !== 1'b1 && k < 400)
        begin
            @(posedge clk);
            #1 k++;
        end
        chk(i_vpd_initiator.rx_q.size(), 7);
        for (k = 0; k < 7 && k < i_vpd_initiator.rx_q.size(); k++)
            chk(i_vpd_initiator.rx_q[k], pg[k]);
    endtask : t_freeze

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fails++;
            close_out();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        chk({req_ready, data_valid, busy}, 3'b100);
        t_refuse();
        t_list();
        t_serial();
        t_opdef();
        t_freeze();
        t_text();
        close_out();
    end
endmodule : tb_top
